// [core/display_supply_fault_supervisor.sv]
// Purpose: supervise three display supply rails and shut them down on faults
// Assumes: comparator flags are synchronous to clk, high when true
// Notes: 1 ms debounce filters restart whenever their flag drops
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - positive rail overcurrent held 1 ms latches shutdown until control cycles
// - analog overcurrent held 1 ms latches shutdown until analog enable cycles
// - positive rail not regulated 10 ms after control high: all rails off
// - negative rail not regulated 12.5 ms after its enable: all rails off
// - negative rail above 250 mV at its enable: panel rails off only
// - analog rail at or below 90 percent for 1 ms while running: all rails off
// - positive rail at or below 80 percent for 1 ms while running: all rails off
// - negative rail above 600 mV for 1 ms while running: all rails off
// - over-temperature stops all rails, automatic restart when flag clears
// - control high enables positive rail at once, negative rail 10 ms later
module display_supply_fault_supervisor #(
  parameter int unsigned DEBOUNCE = supply_supervisor_pkg::DEBOUNCE_CYC,
  parameter int unsigned POS_START = supply_supervisor_pkg::POS_START_CYC,
  parameter int unsigned NEG_ENABLE = supply_supervisor_pkg::NEG_ENABLE_CYC,
  parameter int unsigned NEG_START = supply_supervisor_pkg::NEG_START_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctrl_pin,
  input wire logic analog_enable_pin,
  input wire logic pos_overcurrent_trip,
  input wire logic analog_overcurrent_trip,
  input wire logic pos_in_regulation,
  input wire logic negative_panel_rail_in_regulation,
  input wire logic negative_panel_rail_above_250mv,
  input wire logic negative_panel_rail_above_600mv,
  input wire logic analog_low_90pct,
  input wire logic pos_low_80pct,
  input wire logic thermal_trip_threshold,
  output logic pos_rail_en_reg,
  output logic negative_panel_rail_en_reg,
  output logic analog_rail_en_reg,
  output logic defaults_reset_reg
);
  import supply_supervisor_pkg::*;

  seq_state_t state_reg;
  logic [CNT_W-1:0] seq_cnt_reg;
  logic [CNT_W-1:0] pos_oc_cnt_reg, an_oc_cnt_reg, an_low_cnt_reg;
  logic [CNT_W-1:0] pos_low_cnt_reg, neg_hi_cnt_reg;
  logic pos_latch_reg, an_latch_reg, all_off_reg;
  logic pos_oc_hit, an_oc_hit, an_low_hit, pos_low_hit, neg_hi_hit;
  logic running;

  assign running = (state_reg == ST_RUN);

  // persistence filter: counts while flag high, restarts from zero when low
  function automatic logic [CNT_W-1:0] filt(input logic f,
                                            input logic [CNT_W-1:0] c);
    if (!f)
      filt = '0;
    else if (c < CNT_W'(DEBOUNCE))
      filt = c + 1'b1;
    else
      filt = c;
  endfunction

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_oc_cnt_reg <= '0;
      an_oc_cnt_reg <= '0;
      an_low_cnt_reg <= '0;
      pos_low_cnt_reg <= '0;
      neg_hi_cnt_reg <= '0;
    end
    else
    begin
      pos_oc_cnt_reg <= filt(pos_overcurrent_trip, pos_oc_cnt_reg);
      an_oc_cnt_reg <= filt(analog_overcurrent_trip, an_oc_cnt_reg);
      an_low_cnt_reg <= filt(analog_low_90pct && running, an_low_cnt_reg);
      pos_low_cnt_reg <= filt(pos_low_80pct && running, pos_low_cnt_reg);
      neg_hi_cnt_reg <= filt(negative_panel_rail_above_600mv && running,
                             neg_hi_cnt_reg);
    end
  end

  assign pos_oc_hit = pos_oc_cnt_reg == CNT_W'(DEBOUNCE);
  assign an_oc_hit = an_oc_cnt_reg == CNT_W'(DEBOUNCE);
  assign an_low_hit = an_low_cnt_reg == CNT_W'(DEBOUNCE);
  assign pos_low_hit = pos_low_cnt_reg == CNT_W'(DEBOUNCE);
  assign neg_hi_hit = neg_hi_cnt_reg == CNT_W'(DEBOUNCE);

  // positive overcurrent latch, cleared by control low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pos_latch_reg <= 1'b0;
    else if (pos_oc_hit)
      pos_latch_reg <= 1'b1;
    else if (!ctrl_pin)
      pos_latch_reg <= 1'b0;
  end

  // analog overcurrent latch, cleared by analog enable low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      an_latch_reg <= 1'b0;
    else if (an_oc_hit)
      an_latch_reg <= 1'b1;
    else if (!analog_enable_pin)
      an_latch_reg <= 1'b0;
  end

  // short faults latch all rails off until control and analog enable are low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      all_off_reg <= 1'b0;
    else if (an_low_hit || pos_low_hit || neg_hi_hit)
      all_off_reg <= 1'b1;
    else if (state_reg == ST_POS_UP && seq_cnt_reg >= CNT_W'(POS_START - 1)
             && !pos_in_regulation)
      all_off_reg <= 1'b1;
    else if (state_reg == ST_NEG_UP && seq_cnt_reg >= CNT_W'(NEG_START - 1)
             && !negative_panel_rail_in_regulation)
      all_off_reg <= 1'b1;
    else if (!ctrl_pin && !analog_enable_pin)
      all_off_reg <= 1'b0;
  end

  // panel sequencer on one timebase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_OFF;
      seq_cnt_reg <= '0;
    end
    else if (!ctrl_pin || pos_latch_reg || an_latch_reg || all_off_reg
             || thermal_trip_threshold)
    begin
      state_reg <= ST_OFF;
      seq_cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        ST_OFF:
        begin
          state_reg <= ST_POS_UP;
          seq_cnt_reg <= '0;
        end
        ST_POS_UP:
        begin
          seq_cnt_reg <= seq_cnt_reg + 1'b1;
          if (seq_cnt_reg >= CNT_W'(NEG_ENABLE - 1))
          begin
            seq_cnt_reg <= '0;
            if (negative_panel_rail_above_250mv)
              state_reg <= ST_PANEL_FAULT;
            else
              state_reg <= ST_NEG_UP;
          end
        end
        ST_NEG_UP:
        begin
          seq_cnt_reg <= seq_cnt_reg + 1'b1;
          if (negative_panel_rail_in_regulation)
            state_reg <= ST_RUN;
        end
        ST_RUN: state_reg <= ST_RUN;
        ST_PANEL_FAULT: state_reg <= ST_PANEL_FAULT;
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pos_rail_en_reg <= 1'b0;
      negative_panel_rail_en_reg <= 1'b0;
      analog_rail_en_reg <= 1'b0;
      defaults_reset_reg <= 1'b1;
    end
    else
    begin
      pos_rail_en_reg <= state_reg == ST_POS_UP || state_reg == ST_NEG_UP
                         || running;
      negative_panel_rail_en_reg <= state_reg == ST_NEG_UP || running;
      // either overcurrent shuts the whole device, analog rail included
      analog_rail_en_reg <= analog_enable_pin && !an_latch_reg
                            && !pos_latch_reg && !all_off_reg
                            && !thermal_trip_threshold;
      defaults_reset_reg <= !ctrl_pin && !analog_enable_pin;
    end
  end

  property latch_after(logic f, logic l);
    @(posedge clk) disable iff (rst) f |=> l;
  endproperty

  pos_oc_latch_a: assert property (latch_after(pos_oc_hit, pos_latch_reg))
    else $error("positive overcurrent not latched");
  an_oc_latch_a: assert property (latch_after(an_oc_hit, an_latch_reg))
    else $error("analog overcurrent not latched");
  an_oc_off_a: assert property (@(posedge clk) disable iff (rst)
    an_latch_reg |=> !analog_rail_en_reg)
    else $error("analog rail on while latched");
  pos_oc_off_a: assert property (@(posedge clk) disable iff (rst)
    pos_latch_reg |=> !analog_rail_en_reg ##1 !pos_rail_en_reg)
    else $error("rails on while positive overcurrent latched");
  an_low_a: assert property (latch_after(an_low_hit, all_off_reg))
    else $error("analog low fault missed");
  pos_low_a: assert property (latch_after(pos_low_hit, all_off_reg))
    else $error("positive low fault missed");
  neg_hi_a: assert property (latch_after(neg_hi_hit, all_off_reg))
    else $error("negative high fault missed");
  thermal_off_a: assert property (@(posedge clk) disable iff (rst)
    thermal_trip_threshold |=> !analog_rail_en_reg
    ##1 (!pos_rail_en_reg && !negative_panel_rail_en_reg))
    else $error("rails on during over-temperature");
  filt_restart_a: assert property (@(posedge clk) disable iff (rst)
    !pos_overcurrent_trip |=> pos_oc_cnt_reg == '0)
    else $error("filter did not restart");
  sequence ctrl_rise;
    !ctrl_pin ##1 ctrl_pin;
  endsequence
  pos_start_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_rise ##0 (!pos_latch_reg && !an_latch_reg && !all_off_reg
    && !thermal_trip_threshold)
    ##1 ctrl_pin [*2] |-> pos_rail_en_reg)
    else $error("positive rail not started");
endmodule

`default_nettype wire

// [core/supply_supervisor_pkg.sv]
// Purpose: shared constants for the display supply fault supervisor
// Assumes: 40 MHz clock
// Notes: times are kept in microseconds and turned into cycle counts here
package supply_supervisor_pkg;
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned DEBOUNCE_US = 1000;
  localparam int unsigned POS_START_US = 10000;
  localparam int unsigned NEG_START_US = 12500;
  localparam int unsigned NEG_ENABLE_US = 10000;
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned POS_START_CYC = POS_START_US * CLK_MHZ;
  localparam int unsigned NEG_START_CYC = NEG_START_US * CLK_MHZ;
  localparam int unsigned NEG_ENABLE_CYC = NEG_ENABLE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 20;
  localparam logic [1:0] RESET_RAILS = 2'h0;
  typedef enum logic [2:0] {
    ST_OFF, ST_POS_UP, ST_NEG_UP, ST_RUN, ST_PANEL_FAULT
  } seq_state_t;
endpackage

// [verif/display_supply_fault_supervisor_tb_top.sv]
// Purpose: self-checking bench for the supply fault supervisor
// Assumes: short counts 8, 40, 40, 50 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module display_supply_fault_supervisor_tb_top;
  logic clk = 0, rst = 1, ctrl = 0, aen = 0, poc = 0, aoc = 0, hot = 0;
  logic n250 = 0, n600 = 0, alow = 0, plow = 0, psh = 0, nsh = 0;
  logic pe, ne, ae, dr, pok, nok;
  int failures = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  display_supply_fault_supervisor #(.DEBOUNCE(8), .POS_START(40),
    .NEG_ENABLE(40), .NEG_START(50)) dut (.clk(clk), .rst(rst),
    .ctrl_pin(ctrl), .analog_enable_pin(aen),
    .pos_overcurrent_trip(poc), .analog_overcurrent_trip(aoc),
    .pos_in_regulation(pok), .negative_panel_rail_in_regulation(nok),
    .negative_panel_rail_above_250mv(n250),
    .negative_panel_rail_above_600mv(n600), .analog_low_90pct(alow),
    .pos_low_80pct(plow), .thermal_trip_threshold(hot),
    .pos_rail_en_reg(pe), .negative_panel_rail_en_reg(ne),
    .analog_rail_en_reg(ae), .defaults_reset_reg(dr));
  rail_model model (.clk(clk), .pos_en(pe), .neg_en(ne), .pos_short(psh),
    .neg_short(nsh), .pos_ok(pok), .neg_ok(nok));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic rails(input logic p, input logic n, input logic a);
    chk("pos_rail_en_reg", p, pe);
    chk("negative_panel_rail_en_reg", n, ne);
    chk("analog_rail_en_reg", a, ae);
  endtask
  task automatic bring_up;
    ctrl = 0;
    aen = 0;
    cyc(3);
    aen = 1;
    ctrl = 1;
    cyc(110);
  endtask
  task automatic t_start;
    ctrl = 0;
    aen = 0;
    cyc(3);
    chk("defaults_reset_reg", 1'b1, dr);
    aen = 1;
    ctrl = 1;
    cyc(5);
    rails(1, 0, 1);
    chk("defaults_reset_reg", 1'b0, dr);
    cyc(30);
    rails(1, 0, 1);
    cyc(10);
    rails(1, 1, 1);
    cyc(60);
  endtask
  task automatic t_pos_oc;
    t_start;
    poc = 1;
    cyc(6);
    poc = 0;
    cyc(1);
    poc = 1;
    cyc(6);
    poc = 0;
    cyc(3);
    rails(1, 1, 1);
    poc = 1;
    cyc(12);
    poc = 0;
    cyc(5);
    rails(0, 0, 0);
    ctrl = 0;
    cyc(3);
    ctrl = 1;
    cyc(5);
    rails(1, 0, 1);
  endtask
  task automatic t_ana_oc;
    bring_up;
    aoc = 1;
    cyc(12);
    aoc = 0;
    cyc(5);
    rails(0, 0, 0);
    aen = 0;
    cyc(3);
    aen = 1;
    cyc(5);
    chk("analog_rail_en_reg", 1'b1, ae);
  endtask
  task automatic t_start_faults;
    psh = 1;
    bring_up;
    rails(0, 0, 0);
    psh = 0;
    nsh = 1;
    bring_up;
    rails(0, 0, 0);
    nsh = 0;
    n250 = 1;
    bring_up;
    rails(0, 0, 1);
    n250 = 0;
  endtask
  task automatic t_run_faults;
    for (int i = 0; i < 3; i++)
    begin
      bring_up;
      {alow, plow, n600} = 3'h4 >> i;
      cyc(12);
      {alow, plow, n600} = 3'h0;
      cyc(3);
      rails(0, 0, 0);
    end
  endtask
  task automatic t_hot;
    bring_up;
    hot = 1;
    cyc(5);
    rails(0, 0, 0);
    hot = 0;
    cyc(110);
    rails(1, 1, 1);
    rst = 1;
    cyc(2);
    rails(0, 0, 0);
    chk("defaults_reset_reg", 1'b1, dr);
    rst = 0;
  endtask
  task automatic conclude;
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    rst = 0;
    t_start;
    t_pos_oc;
    t_ana_oc;
    t_start_faults;
    t_run_faults;
    t_hot;
    conclude;
  end
  initial
  begin
    #125000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire

// [verif/rail_model.sv]
// Purpose: far-side model of the two panel rails
// Assumes: a rail regulates one cycle after its enable
// Notes: a commanded short keeps that rail out of regulation
`timescale 1ns/1ps
`default_nettype none
module rail_model (
  input wire logic clk,
  input wire logic pos_en,
  input wire logic neg_en,
  input wire logic pos_short,
  input wire logic neg_short,
  output logic pos_ok,
  output logic neg_ok
);
  always_ff @(posedge clk)
  begin
    pos_ok <= pos_en & ~pos_short;
    neg_ok <= neg_en & ~neg_short;
  end
endmodule
`default_nettype wire
